// File: include/hrs_pkg.sv
// Purpose: Shared constants and state types for the hall result and setup registers.
// Assumes: One 125 MHz clock and a synchronous active-low reset.
// Notes: Register offsets are the byte addresses seen on the register port.
package hrs_pkg;

  // Register offsets.
  localparam logic [7:0] HRS_OFS_X_MSB = 8'h00;
  localparam logic [7:0] HRS_OFS_Y_MSB = 8'h01;
  localparam logic [7:0] HRS_OFS_Z_MSB = 8'h02;
  localparam logic [7:0] HRS_OFS_T_MSB = 8'h03;
  localparam logic [7:0] HRS_OFS_XY_LOW = 8'h04;
  localparam logic [7:0] HRS_OFS_TZ_LOW = 8'h05;
  localparam logic [7:0] HRS_OFS_SETUP = 8'h10;

  // Setup register field positions.
  localparam int unsigned HRS_THERMAL_OFF_BIT = 7;
  localparam int unsigned HRS_PLANAR_ONLY_BIT = 6;
  localparam int unsigned HRS_CONV_ON_READ_SEL_SEL_LSB = 4;
  localparam int unsigned HRS_DOUBLE_GAIN_BIT = 3;
  localparam int unsigned HRS_MAGNET_TC_LSB = 1;
  localparam int unsigned HRS_PARITY_BIT = 0;

  // Conversion-on-read selector codes; any code with the upper bit set means after the low byte.
  localparam logic [1:0] HRS_CONV_ON_READ_SEL_NONE = 2'h0;
  localparam logic [1:0] HRS_CONV_ON_READ_SEL_FIRST = 2'h1;

  // Values after reset.
  localparam logic [7:0] HRS_SETUP_RST = 8'h00;
  localparam logic [7:0] HRS_RDATA_RST = 8'h00;
  localparam logic [11:0] HRS_FIELD_RST = 12'h800;
  localparam logic [11:0] HRS_TEMP_RST = 12'h800;

  // Conversion tracking states.
  typedef enum logic [1:0] {
    HRS_IDLE = 2'h0,
    HRS_BUSY = 2'h1
  } hrs_conv_e;

  // Settings handed to the converter for one conversion.
  typedef struct packed {
    logic temp_en;
    logic z_en;
    logic double_gain;
    logic [1:0] magnet_tc_sel;
  } hrs_act_s;

  // State of the top module.
  typedef struct packed {
    hrs_conv_e st;
    logic [7:0] setup;
    hrs_act_s act;
    logic [7:0] rdata;
    logic pok;
  } hrs_core_s;

  // State of the result store.
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] t;
  } hrs_store_s;

  localparam hrs_act_s HRS_ACT_RST = '{1'b1, 1'b1, 1'b0, 2'h0};
  localparam hrs_core_s HRS_CORE_RST = '{HRS_IDLE, HRS_SETUP_RST, HRS_ACT_RST, HRS_RDATA_RST, 1'b1};
  localparam hrs_store_s HRS_STORE_RST = '{HRS_FIELD_RST, HRS_FIELD_RST, HRS_FIELD_RST, HRS_TEMP_RST};

  // True when a read strobe targets the given offset.
  function automatic logic hrs_rd_hit(input logic rd, input logic [7:0] addr, input logic [7:0] ofs);
    hrs_rd_hit = rd && (addr == ofs);
  endfunction : hrs_rd_hit

endpackage : hrs_pkg

// File: include/hrs_res_if.sv
// Purpose: Carries the stored conversion results from the store to the register reader.
// Assumes: Both ends run on the same clock.
// Notes: Values are held results, not live converter data.
interface hrs_res_if;
  logic [11:0] x;
  logic [11:0] y;
  logic [11:0] z;
  logic [11:0] t;
  modport store (output x, y, z, t);
  modport view (input x, y, z, t);
endinterface : hrs_res_if

// File: rtl/hrs_result_store.sv
// Purpose: Holds the last X, Y, Z and temperature results.
// Assumes: i_done is a one-cycle pulse with valid results beside it.
// Notes: Disabled channels are written back to their reset values.
module hrs_result_store (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Converter side.
  input wire logic i_done,
  input wire logic i_temp_en,
  input wire logic i_z_en,
  input wire logic [11:0] i_res_x,
  input wire logic [11:0] i_res_y,
  input wire logic [11:0] i_res_z,
  input wire logic [11:0] i_res_t,
  // Stored results.
  hrs_res_if.store res
);
  import hrs_pkg::*;

  hrs_store_s q;
  hrs_store_s d;

  // A finished conversion overwrites every channel; disabled ones fall back to reset values.
  always_comb begin
    d = q;
    if (i_done) begin
      d.x = i_res_x;
      d.y = i_res_y;
      d.z = i_z_en ? i_res_z : HRS_FIELD_RST;
      d.t = i_temp_en ? i_res_t : HRS_TEMP_RST;
    end
  end

  // State register.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q <= HRS_STORE_RST;
    end else begin
      q <= d;
    end
  end

  // Results go out unchanged.
  assign res.x = q.x;
  assign res.y = q.y;
  assign res.z = q.z;
  assign res.t = q.t;

  xy_capture_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_done |=> (res.x == $past(i_res_x)) && (res.y == $past(i_res_y)))
    else $error("X or Y result not captured.");

endmodule : hrs_result_store

// File: rtl/hrs_read_trigger.sv
// Purpose: Raises a conversion request when a read matches the selected trigger point.
// Assumes: Read strobes are one cycle long.
// Notes: The request is a one-cycle pulse one cycle after the read.
module hrs_read_trigger (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Read port view.
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  // Selection.
  input wire logic i_short_read_sel,
  input wire logic [1:0] i_conv_on_read_sel_sel,
  // Request.
  output logic o_conv_on_read_sel
);
  import hrs_pkg::*;

  logic q;
  logic d;

  // Only the one-byte protocol lets the selector start conversions.
  always_comb begin
    d = 1'b0;
    if (i_short_read_sel) begin
      d = ((i_conv_on_read_sel_sel == HRS_CONV_ON_READ_SEL_FIRST) && hrs_rd_hit(i_rd, i_addr, HRS_OFS_X_MSB)) ||
          (i_conv_on_read_sel_sel[1] && hrs_rd_hit(i_rd, i_addr, HRS_OFS_TZ_LOW));
    end
  end

  // Request register.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign o_conv_on_read_sel = q;

endmodule : hrs_read_trigger

// File: rtl/hrs_result_setup_regs.sv
// Purpose: Low result bytes, address echo and conversion setup register of a 3-axis hall sensor.
// Assumes: Register strobes and converter signals come from logic on the same clock.
// Notes: Settings are frozen for the length of a conversion.
module hrs_result_setup_regs (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Mode register fields.
  input wire logic i_short_read_sel,
  input wire logic [1:0] i_bus_addr_sel,
  // Converter.
  input wire logic i_conv_start,
  input wire logic i_conv_done,
  input wire logic [11:0] i_res_x,
  input wire logic [11:0] i_res_y,
  input wire logic [11:0] i_res_z,
  input wire logic [11:0] i_res_t,
  output logic o_conv_conv_on_read_sel,
  output logic o_temp_en,
  output logic o_z_en,
  output logic o_double_gain,
  output logic [1:0] o_magnet_tc_sel,
  // Diagnostic flag.
  output logic o_setup_parity_ok
);
  import hrs_pkg::*;

  hrs_core_s q;
  hrs_core_s d;
  hrs_res_if res ();
  logic done_ok;

  // A finish is only taken while a conversion is open.
  assign done_ok = i_conv_done && (q.st == HRS_BUSY);

  // True when a write strobe targets the setup register.
  function automatic logic setup_wr(input logic wr, input logic [7:0] addr);
    setup_wr = wr && (addr == HRS_OFS_SETUP);
  endfunction : setup_wr

  // Result store, fed with the settings the running conversion used.
  hrs_result_store u_store (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_done(done_ok),
    .i_temp_en(q.act.temp_en),
    .i_z_en(q.act.z_en),
    .i_res_x(i_res_x),
    .i_res_y(i_res_y),
    .i_res_z(i_res_z),
    .i_res_t(i_res_t),
    .res(res.store)
  );

  // Conversion requests raised by reads.
  hrs_read_trigger u_conv_on_read_sel (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_rd(i_reg_rd),
    .i_addr(i_reg_addr),
    .i_short_read_sel(i_short_read_sel),
    .i_conv_on_read_sel_sel(q.setup[HRS_CONV_ON_READ_SEL_SEL_LSB +: 2]),
    .o_conv_on_read_sel(o_conv_conv_on_read_sel)
  );

  // Next state: setup write, settings snapshot, conversion tracking and read data.
  always_comb begin
    d = q;
    if (setup_wr(i_reg_wr, i_reg_addr)) begin
      d.setup = i_reg_wdata;
    end
    // Even parity over all eight bits, including the parity bit.
    d.pok = ~^d.setup;
    case (q.st)
      HRS_IDLE: begin
        // Settings follow the setup register in every idle cycle, the start cycle included,
        // so a write made during one conversion reaches the next even when it starts at once.
        d.act.temp_en = !q.setup[HRS_THERMAL_OFF_BIT];
        d.act.z_en = !(q.setup[HRS_THERMAL_OFF_BIT] && q.setup[HRS_PLANAR_ONLY_BIT]);
        d.act.double_gain = q.setup[HRS_DOUBLE_GAIN_BIT];
        d.act.magnet_tc_sel = q.setup[HRS_MAGNET_TC_LSB +: 2];
        if (i_conv_start) begin
          d.st = HRS_BUSY;
        end
      end
      HRS_BUSY: begin
        if (i_conv_done) begin
          d.st = HRS_IDLE;
        end
      end
      default: begin
        d.st = HRS_IDLE;
      end
    endcase
    d.rdata = HRS_RDATA_RST;
    if (i_reg_rd) begin
      case (i_reg_addr)
        HRS_OFS_X_MSB: d.rdata = res.x[11:4];
        HRS_OFS_Y_MSB: d.rdata = res.y[11:4];
        HRS_OFS_Z_MSB: d.rdata = res.z[11:4];
        HRS_OFS_T_MSB: d.rdata = res.t[11:4];
        HRS_OFS_XY_LOW: d.rdata = {res.x[3:0], res.y[3:0]};
        HRS_OFS_TZ_LOW: d.rdata = {res.t[3:2], i_bus_addr_sel, res.z[3:0]};
        HRS_OFS_SETUP: d.rdata = q.setup;
        default: d.rdata = HRS_RDATA_RST;
      endcase
    end
  end

  // State register.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q <= HRS_CORE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign o_reg_rdata = q.rdata;
  assign o_temp_en = q.act.temp_en;
  assign o_z_en = q.act.z_en;
  // Gain applies to the field channels only; temperature stays full range.
  assign o_double_gain = q.act.double_gain;
  assign o_magnet_tc_sel = q.act.magnet_tc_sel;
  assign o_setup_parity_ok = q.pok;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  // A read trigger is a single pulse.
  sequence conv_on_read_sel_pulse_s;
    o_conv_conv_on_read_sel ##1 !o_conv_conv_on_read_sel;
  endsequence

  // A read of the first high byte under the one-byte protocol with early trigger.
  sequence first_read_s;
    i_reg_rd && (i_reg_addr == HRS_OFS_X_MSB) && i_short_read_sel &&
      (q.setup[HRS_CONV_ON_READ_SEL_SEL_LSB +: 2] == HRS_CONV_ON_READ_SEL_FIRST);
  endsequence

  xy_low_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_XY_LOW) |=> o_reg_rdata == {$past(res.x[3:0]), $past(res.y[3:0])})
    else $error("XY low byte wrong.");

  tz_low_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_TZ_LOW) |=>
      o_reg_rdata == {$past(res.t[3:2]), $past(i_bus_addr_sel), $past(res.z[3:0])})
    else $error("Temperature, echo or Z low byte wrong.");

  z_off_zero_a: assert property (
    done_ok && !o_z_en |=> res.z[3:0] == 4'h0)
    else $error("Disabled Z low bits not zero.");

  temp_off_rst_a: assert property (
    done_ok && !o_temp_en |=> res.t == HRS_TEMP_RST)
    else $error("Disabled temperature not at reset value.");

  planar_ignored_a: assert property (
    (q.st == HRS_IDLE) && !i_conv_start && !q.setup[HRS_THERMAL_OFF_BIT] |=> o_z_en && o_temp_en)
    else $error("Z or temperature off while temperature enabled.");

  long_no_conv_on_read_sel_a: assert property (
    !i_short_read_sel |=> !o_conv_conv_on_read_sel)
    else $error("Trigger under two-byte protocol.");

  first_conv_on_read_sel_a: assert property (
    first_read_s ##1 !i_reg_rd |-> conv_on_read_sel_pulse_s)
    else $error("Early read trigger missing.");

  odd_setup_flag_a: assert property (
    i_reg_wr && (i_reg_addr == HRS_OFS_SETUP) && (^i_reg_wdata) |=> !o_setup_parity_ok)
    else $error("Odd setup parity not flagged.");

  reset_parity_a: assert property (@(posedge i_clock) disable iff (1'b0)
    !i_nrst |=> o_setup_parity_ok && (q.setup == HRS_SETUP_RST))
    else $error("Parity flag clear after reset.");

  busy_frozen_a: assert property (
    (q.st == HRS_BUSY) |=> $stable(o_double_gain) && $stable(o_magnet_tc_sel) && $stable(o_z_en))
    else $error("Settings changed during conversion.");

  // Each high byte comes from the matching stored result.
  x_msb_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_X_MSB) |=> o_reg_rdata == $past(res.x[11:4]))
    else $error("X high byte wrong.");

  y_msb_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_Y_MSB) |=> o_reg_rdata == $past(res.y[11:4]))
    else $error("Y high byte wrong.");

  z_msb_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_Z_MSB) |=> o_reg_rdata == $past(res.z[11:4]))
    else $error("Z high byte wrong.");

  t_msb_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_T_MSB) |=> o_reg_rdata == $past(res.t[11:4]))
    else $error("Temperature high byte wrong.");

  // Without a read the data output rests at zero.
  rdata_idle_a: assert property (
    !i_reg_rd |=> o_reg_rdata == HRS_RDATA_RST)
    else $error("Read data not zero without a read.");

  // The setup register takes every write to its offset and reads back as stored.
  setup_read_a: assert property (
    i_reg_rd && (i_reg_addr == HRS_OFS_SETUP) |=> o_reg_rdata == $past(q.setup))
    else $error("Setup readback wrong.");

  setup_write_a: assert property (
    setup_wr(i_reg_wr, i_reg_addr) |=> q.setup == $past(i_reg_wdata))
    else $error("Setup write lost.");

  even_setup_flag_a: assert property (
    setup_wr(i_reg_wr, i_reg_addr) && !(^i_reg_wdata) |=> o_setup_parity_ok)
    else $error("Even setup parity not flagged.");

  flag_hold_a: assert property (
    !setup_wr(i_reg_wr, i_reg_addr) |=> $stable(o_setup_parity_ok))
    else $error("Parity flag moved without a write.");

  // Settings taken while idle follow the setup bits one cycle later.
  temp_off_a: assert property (
    (q.st == HRS_IDLE) && q.setup[HRS_THERMAL_OFF_BIT] |=> !o_temp_en)
    else $error("Temperature still enabled.");

  xy_only_a: assert property (
    (q.st == HRS_IDLE) && q.setup[HRS_THERMAL_OFF_BIT] && q.setup[HRS_PLANAR_ONLY_BIT] |=>
      !o_z_en && !o_temp_en)
    else $error("Z or temperature on in planar mode.");

  z_kept_a: assert property (
    (q.st == HRS_IDLE) && !q.setup[HRS_PLANAR_ONLY_BIT] |=> o_z_en)
    else $error("Z off with planar bit clear.");

  gain_follow_a: assert property (
    (q.st == HRS_IDLE) |=> o_double_gain == $past(q.setup[HRS_DOUBLE_GAIN_BIT]))
    else $error("Gain setting not taken.");

  curve_follow_a: assert property (
    (q.st == HRS_IDLE) |=> o_magnet_tc_sel == $past(q.setup[HRS_MAGNET_TC_LSB +: 2]))
    else $error("Compensation curve not taken.");

  // A read of the temperature and Z low byte at the late trigger point.
  sequence late_read_s;
    i_reg_rd && (i_reg_addr == HRS_OFS_TZ_LOW) && i_short_read_sel && q.setup[HRS_CONV_ON_READ_SEL_SEL_LSB + 1];
  endsequence

  late_conv_on_read_sel_a: assert property (
    late_read_s |=> o_conv_conv_on_read_sel)
    else $error("Late read trigger missing.");

  no_conv_on_read_sel_sel_a: assert property (
    (q.setup[HRS_CONV_ON_READ_SEL_SEL_LSB +: 2] == HRS_CONV_ON_READ_SEL_NONE) |=> !o_conv_conv_on_read_sel)
    else $error("Trigger with no trigger point selected.");

  // Enabled channels store the result of the finishing conversion.
  z_on_store_a: assert property (
    done_ok && o_z_en |=> res.z == $past(i_res_z))
    else $error("Enabled Z result not stored.");

  temp_on_store_a: assert property (
    done_ok && o_temp_en |=> res.t == $past(i_res_t))
    else $error("Enabled temperature result not stored.");

  // A start while idle opens a conversion, a finish closes it, and a finish while idle is ignored.
  conv_open_a: assert property (
    (q.st == HRS_IDLE) && i_conv_start |=> (q.st == HRS_BUSY))
    else $error("Start did not open a conversion.");

  idle_done_a: assert property (
    (q.st == HRS_IDLE) && !i_conv_start |=> (q.st == HRS_IDLE))
    else $error("Conversion opened without a start.");

  conv_close_a: assert property (
    (q.st == HRS_BUSY) && i_conv_done |=> (q.st == HRS_IDLE))
    else $error("Finish did not close the conversion.");

endmodule : hrs_result_setup_regs

// File: verif/hrs_conv_model.sv
// Purpose: Converter model that answers start requests with timed results.
// Assumes: Driven on the falling clock edge like all other stimulus.
// Notes: Results change every cycle, so only the done cycle carries a usable value.
module hrs_conv_model (
  // Clock.
  input wire logic i_clock,
  // Requests from the bench and from the read trigger.
  input wire logic i_go,
  input wire logic i_conv_on_read_sel,
  // Converter outputs.
  output logic o_start,
  output logic o_done,
  output logic [47:0] o_res
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h7f15000d;
  int cnt = 0;
  // Opens a conversion only while idle, so no start ever lands inside a conversion.
  always @(negedge i_clock) begin
    o_start <= 1'b0;
    o_done <= (cnt == 1);
    o_res <= 48'({$random(seed), $random(seed)});
    if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (i_go || i_conv_on_read_sel) begin
      o_start <= 1'b1;
      cnt <= 5;
    end
  end
endmodule : hrs_conv_model

// File: verif/hall_result_and_setup_regs_tb.sv
// Purpose: Self-checking bench for the result and setup registers.
// Assumes: Stimulus changes on the falling edge; the design samples on the rising edge.
// Notes: A reference model predicts read data, trigger pulses, parity and frozen settings.
module hall_result_and_setup_regs_tb import hrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic nrst = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0, sel = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d;
  logic [1:0] asel = 2'h0, tc;
  logic [7:0] rdata, m_set, m_snap, exp_rd;
  logic conv_on_read_sel, ten, zen, dg, pok, start, done, exp_conv_on_read_sel, m_busy;
  logic [47:0] res;
  logic [11:0] m_x, m_y, m_z, m_t;
  int err_count = 0, checked = 0, cycles = 0, seed;
  hrs_result_setup_regs u_dut (.i_clock(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_short_read_sel(sel), .i_bus_addr_sel(asel),
    .i_conv_start(start), .i_conv_done(done), .i_res_x(res[47:36]), .i_res_y(res[35:24]),
    .i_res_z(res[23:12]), .i_res_t(res[11:0]), .o_conv_conv_on_read_sel(conv_on_read_sel), .o_temp_en(ten), .o_z_en(zen),
    .o_double_gain(dg), .o_magnet_tc_sel(tc), .o_setup_parity_ok(pok));
  hrs_conv_model u_conv (.i_clock(clk), .i_go(go), .i_conv_on_read_sel(conv_on_read_sel), .o_start(start), .o_done(done), .o_res(res));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdr(input logic [7:0] a);
    @(negedge clk) begin rd <= 1'b1; addr <= a; end
    @(negedge clk) rd <= 1'b0;
    if (a == HRS_OFS_TZ_LOW) check(8'(rdata[5:4]), 8'(asel));
  endtask : rdr
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(negedge clk) wr <= 1'b0;
  endtask : wrr
  // Reference model: reads see the store before this edge, writes land after it.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end else if (!nrst) begin
      m_set = HRS_SETUP_RST; m_snap = 8'h00; m_busy = 1'b0; exp_rd = 8'h00; exp_conv_on_read_sel = 1'b0;
      m_x = HRS_FIELD_RST; m_y = HRS_FIELD_RST; m_z = HRS_FIELD_RST; m_t = HRS_TEMP_RST;
    end else begin
      exp_rd = 8'h00;
      if (rd) case (addr)
        HRS_OFS_X_MSB: exp_rd = m_x[11:4];
        HRS_OFS_Y_MSB: exp_rd = m_y[11:4];
        HRS_OFS_Z_MSB: exp_rd = m_z[11:4];
        HRS_OFS_T_MSB: exp_rd = m_t[11:4];
        HRS_OFS_XY_LOW: exp_rd = {m_x[3:0], m_y[3:0]};
        HRS_OFS_TZ_LOW: exp_rd = {m_t[3:2], asel, m_z[3:0]};
        HRS_OFS_SETUP: exp_rd = m_set;
        default: exp_rd = 8'h00;
      endcase
      exp_conv_on_read_sel = rd && sel && ((m_set[5:4] == HRS_CONV_ON_READ_SEL_FIRST && addr == HRS_OFS_X_MSB)
        || (m_set[5] && addr == HRS_OFS_TZ_LOW));
      if (done && m_busy) begin
        m_busy = 1'b0; m_x = res[47:36]; m_y = res[35:24];
        m_z = (m_snap[7] && m_snap[6]) ? HRS_FIELD_RST : res[23:12];
        m_t = m_snap[7] ? HRS_TEMP_RST : res[11:0];
      end else if (start && !m_busy) begin
        m_busy = 1'b1; m_snap = m_set;
      end
      if (wr && addr == HRS_OFS_SETUP) m_set = wdata;
    end
  end
  // Compares read data, trigger and parity against the model once per cycle, and the settings only while busy, where values are settled.
  always @(negedge clk) begin
    if (cycles > 1) begin
      check(rdata, exp_rd);
      check(8'(conv_on_read_sel), 8'(exp_conv_on_read_sel));
      check(8'(pok), 8'(~^m_set));
      if (m_busy) check({ten, zen, dg, tc, 3'h0},
        {~m_snap[7], ~(m_snap[7] & m_snap[6]), m_snap[3], m_snap[2:1], 3'h0});
    end
  end
  // Main sequence.
  initial begin
    seed = 32'h7f15000d;
    repeat (8) @(negedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rdr(i == 7 ? HRS_OFS_SETUP : 8'(i));
    rdr(8'hFF);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin asel <= 2'(i); rdr(HRS_OFS_TZ_LOW); end
    $display("test address echo done");
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      d[7:6] = 2'(i);
      d[3] = i[2];
      d[2:1] = 2'(i >> 2);
      d[0] = ^d[7:1] ^ (i > 11);
      asel <= 2'($random(seed));
      wrr(HRS_OFS_SETUP, d);
      wrr(HRS_OFS_XY_LOW, ~d);
      repeat (3) @(negedge clk);
      @(negedge clk) go <= 1'b1;
      @(negedge clk) go <= 1'b0;
      repeat (8) @(negedge clk);
      for (int a = 0; a < 6; a++) @(negedge clk) begin rd <= 1'b1; addr <= 8'(a); end
      @(negedge clk) rd <= 1'b0;
    end
    $display("test setup and conversion done");
    for (int i = 0; i < 8; i++) begin
      d = {2'h0, 2'(i), 4'h0};
      d[0] = ^d;
      wrr(HRS_OFS_SETUP, d);
      repeat (3) @(negedge clk);
      sel <= i[2];
      rdr(HRS_OFS_X_MSB);
      rdr(HRS_OFS_TZ_LOW);
      repeat (8) @(negedge clk);
    end
    sel <= 1'b0;
    $display("test read trigger done");
    wrr(HRS_OFS_SETUP, 8'h00);
    repeat (3) @(negedge clk);
    @(negedge clk) go <= 1'b1;
    @(negedge clk) go <= 1'b0;
    wrr(HRS_OFS_SETUP, 8'hC9);
    repeat (8) @(negedge clk);
    // The setup written during the last conversion must drive the next one.
    @(negedge clk) go <= 1'b1;
    @(negedge clk) go <= 1'b0;
    repeat (8) @(negedge clk);
    rdr(HRS_OFS_TZ_LOW);
    @(negedge clk) begin rd <= 1'b1; wr <= 1'b1; addr <= HRS_OFS_SETUP; wdata <= 8'h03; end
    @(negedge clk) begin rd <= 1'b0; wr <= 1'b0; end
    rdr(HRS_OFS_SETUP);
    $display("test write during conversion done");
    @(negedge clk) nrst <= 1'b0;
    repeat (2) @(negedge clk);
    nrst <= 1'b1;
    rdr(HRS_OFS_SETUP);
    rdr(HRS_OFS_X_MSB);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : hall_result_and_setup_regs_tb
